// File: rtl/dac_channel_loader.sv
// converter end: shift register, load decode and channel latches
//
// Behaviour
// - twelve bit frame: address high, code low
// - host shifts bit eleven first
// - rising shift clock shifts input into bit zero
// - serial output shows shift register top bit
// - strobe high writes code to addressed latch
// - address bit eight weighs eight, reversed
// - code n gives low plus n steps
// - host limits shift clock rate
// - devices chain output to next input
`timescale 1ns/1ns
`include "dac_loader_defs.svh"
module dac_channel_loader #(
  parameter int CHANNELS = `CHAN_COUNT
) (
  input wire logic clock,
  input wire logic rstn,
  dac_link_if.device link,
  output dac_loader_pkg::code_t channel_outputs [CHANNELS],
  output logic [15:0] code_step_level [CHANNELS]
);
  import dac_loader_pkg::*;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] din_sync_r;
  logic [2:0] sclk_sync_r;
  logic [2:0] strobe_sync_r;
  logic din_r;
  logic sclk_r;
  logic strobe_r;
  logic sclk_prev_r;
  frame_t shift_r;

  // three stages; a change counts once stages two and three agree
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      din_sync_r <= 3'h0;
      sclk_sync_r <= 3'h0;
      strobe_sync_r <= 3'h0;
    end else begin
      din_sync_r <= {din_sync_r[1:0], link.serial_frame_in};
      sclk_sync_r <= {sclk_sync_r[1:0], link.shift_clock};
      strobe_sync_r <= {strobe_sync_r[1:0], link.latch_strobe};
    end
  end

  // filtered levels only move when the last two stages agree
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      din_r <= 1'b0;
      sclk_r <= 1'b0;
      strobe_r <= 1'b0;
      sclk_prev_r <= 1'b0;
    end else begin
      if (din_sync_r[1] == din_sync_r[2]) din_r <= din_sync_r[2];
      if (sclk_sync_r[1] == sclk_sync_r[2]) sclk_r <= sclk_sync_r[2];
      if (strobe_sync_r[1] == strobe_sync_r[2])
        strobe_r <= strobe_sync_r[2];
      sclk_prev_r <= sclk_r;
    end
  end

  // ----------------------------------------------------------------
  // shift register
  // ----------------------------------------------------------------
  // data path lags clock path by the same stages, so setup is kept
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      shift_r <= '0;
    end else if (sclk_r && !sclk_prev_r) begin
      shift_r <= {shift_r[`FRAME_BITS-2:0], din_r};
    end
  end

  assign link.serial_frame_out = shift_r[`FRAME_BITS-1];

  // ----------------------------------------------------------------
  // address decode and channel latches
  // ----------------------------------------------------------------
  // bit eleven weighs one, so the field is read bit reversed
  function automatic addr_t decode_addr(input frame_t f);
    decode_addr = {f[8], f[9], f[10], f[11]};
  endfunction : decode_addr

  addr_t sel_addr;
  assign sel_addr = decode_addr(shift_r);

  // level sensitive in effect: rewritten every cycle strobe is high
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < CHANNELS; i++) channel_outputs[i] <= 8'h00;
    end else if (strobe_r) begin
      for (int i = 0; i < CHANNELS; i++) begin
        // codes 0 and 13..15 match nothing and change nothing
        if (sel_addr == 4'(i + 1))
          channel_outputs[i] <= shift_r[`CODE_MSB:`CODE_LSB];
      end
    end
  end

  // output level in steps of span/255, scaled by 257 for a 16-bit word
  always_comb begin
    for (int i = 0; i < CHANNELS; i++)
      code_step_level[i] = {channel_outputs[i], channel_outputs[i]};
  end
endmodule : dac_channel_loader

// File: rtl/dac_link_if.sv
// three wire link plus chain output between host and converter
`timescale 1ns/1ns
interface dac_link_if;
  logic serial_frame_in;
  logic shift_clock;
  logic latch_strobe;
  logic serial_frame_out;
  modport host (
    output serial_frame_in,
    output shift_clock,
    output latch_strobe,
    input serial_frame_out
  );
  modport device (
    input serial_frame_in,
    input shift_clock,
    input latch_strobe,
    output serial_frame_out
  );
endinterface : dac_link_if

// File: rtl/dac_loader_defs.svh
// timing and field constants for the serial channel loader
`ifndef DAC_LOADER_DEFS_SVH
`define DAC_LOADER_DEFS_SVH
`define FRAME_BITS 12
`define ADDR_MSB 11
`define ADDR_LSB 8
`define CODE_MSB 7
`define CODE_LSB 0
`define CHAN_COUNT 12
`define CHAN_FIRST 4'h1
`define CHAN_LAST 4'hC
`define CODE_FULL 8'hFF
`define CLK_FREQ_HZ 125000000
`define LINK_HALF_NS 200
`define LINK_HALF_CYC ((`LINK_HALF_NS * 125 + 999) / 1000)
`define STROBE_HIGH_NS 100
`define STROBE_HIGH_CYC ((`STROBE_HIGH_NS * 125 + 999) / 1000)
`endif

// File: rtl/dac_loader_pkg.sv
// types shared by both ends of the serial channel loader
package dac_loader_pkg;
  typedef logic [11:0] frame_t;
  typedef logic [7:0] code_t;
  typedef logic [3:0] addr_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_LOW = 3'b001,
    ST_HIGH = 3'b010,
    ST_STROBE = 3'b011,
    ST_GAP = 3'b100
  } host_state_t;
endpackage : dac_loader_pkg

// File: rtl/dac_serial_host.sv
// host end: shifts frames out over the three wire link
`timescale 1ns/1ns
`include "dac_loader_defs.svh"
module dac_serial_host #(
  parameter int HALF_CYC = `LINK_HALF_CYC,
  parameter int STROBE_CYC = `STROBE_HIGH_CYC
) (
  input wire logic clock,
  input wire logic rstn,
  dac_link_if.host link,
  input wire logic frame_valid,
  output logic frame_ready,
  input wire dac_loader_pkg::frame_t frame_data,
  input wire logic frame_last,
  output logic busy
);
  import dac_loader_pkg::*;

  host_state_t state_r;
  frame_t data_r;
  logic last_r;
  logic [3:0] bit_r;
  logic [7:0] cnt_r;
  logic sclk_r;
  logic sdo_r;
  logic strobe_r;

  assign frame_ready = (state_r == ST_IDLE);
  assign busy = (state_r != ST_IDLE);
  assign link.serial_frame_in = sdo_r;
  assign link.shift_clock = sclk_r;
  assign link.latch_strobe = strobe_r;

  // ----------------------------------------------------------------
  // frame sequencer
  // ----------------------------------------------------------------
  // divider holds each half at 200 ns, the single device limit;
  // a chain of converters needs a larger HALF_CYC to stay legal
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_r <= ST_IDLE;
      data_r <= '0;
      last_r <= 1'b0;
      bit_r <= 4'h0;
      cnt_r <= 8'h00;
      sclk_r <= 1'b0;
      sdo_r <= 1'b0;
      strobe_r <= 1'b0;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (frame_valid) begin
            data_r <= frame_data;
            last_r <= frame_last;
            bit_r <= 4'h0;
            sdo_r <= frame_data[`FRAME_BITS-1];
            cnt_r <= 8'h00;
            state_r <= ST_LOW;
          end
        end
        ST_LOW: begin
          if (cnt_r == 8'(HALF_CYC - 1)) begin
            cnt_r <= 8'h00;
            sclk_r <= 1'b1;
            state_r <= ST_HIGH;
          end else cnt_r <= cnt_r + 8'h01;
        end
        ST_HIGH: begin
          if (cnt_r == 8'(HALF_CYC - 1)) begin
            cnt_r <= 8'h00;
            sclk_r <= 1'b0;
            data_r <= {data_r[`FRAME_BITS-2:0], 1'b0};
            sdo_r <= data_r[`FRAME_BITS-2];
            if (bit_r == 4'(`FRAME_BITS - 1)) begin
              // strobe only after the final edge, once per chain
              state_r <= last_r ? ST_STROBE : ST_IDLE;
            end else begin
              bit_r <= bit_r + 4'h1;
              state_r <= ST_LOW;
            end
          end else cnt_r <= cnt_r + 8'h01;
        end
        ST_STROBE: begin
          if (cnt_r == 8'(HALF_CYC - 1)) begin
            cnt_r <= 8'h00;
            strobe_r <= 1'b1;
            state_r <= ST_GAP;
          end else cnt_r <= cnt_r + 8'h01;
        end
        ST_GAP: begin
          // strobe width set on its own, apart from the clock halves
          if (cnt_r == 8'(STROBE_CYC - 1)) begin
            cnt_r <= 8'h00;
            strobe_r <= 1'b0;
            state_r <= ST_IDLE;
          end else cnt_r <= cnt_r + 8'h01;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end
endmodule : dac_serial_host

// File: test/dac_link_properties.sv
// concurrent checks on the host to converter link
`timescale 1ns/1ns
module dac_link_properties (
  input wire logic clock,
  input wire logic rstn,
  input wire logic serial_frame_in,
  input wire logic shift_clock,
  input wire logic latch_strobe,
  input wire logic serial_frame_out
);
  logic [11:0] shadow_r;
  logic [3:0] rises_r;
  // ----
  // helper logic
  // ----
  // reference shift register, sampled as the converter samples
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      shadow_r <= 12'h000;
    end else if ($rose(shift_clock)) begin
      shadow_r <= {shadow_r[10:0], serial_frame_in};
    end
  end
  // rising edges modulo one frame; a strobe must land on zero
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rises_r <= 4'h0;
    end else if ($rose(shift_clock)) begin
      rises_r <= (rises_r == 4'hB) ? 4'h0 : rises_r + 4'h1;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  clk_high_a: assert property (
    $rose(shift_clock) |-> ##25 $fell(shift_clock)) else $error("high half");
  clk_low_a: assert property (
    $fell(shift_clock) |=> !shift_clock[*8]) else $error("low half short");
  data_setup_a: assert property (
    $changed(serial_frame_in) |-> !shift_clock) else $error("data moved");
  strobe_width_a: assert property (
    $rose(latch_strobe) |-> ##13 $fell(latch_strobe)) else $error("strobe");
  strobe_quiet_a: assert property (
    latch_strobe |-> !shift_clock) else $error("clock during strobe");
  whole_frames_a: assert property (
    $rose(latch_strobe) |-> rises_r == 4'h0) else $error("partial frame");
  out_echo_a: assert property (
    $fell(shift_clock) |-> serial_frame_out == shadow_r[11]) else $error("msb");
  out_strobe_a: assert property (
    latch_strobe |-> serial_frame_out == shadow_r[11]) else $error("out");
endmodule : dac_link_properties

// File: test/tb_serial_dac_channel_loader.sv
// self-checking bench: host end loads converter end over the link
`timescale 1ns/1ns
module tb_serial_dac_channel_loader;
  import dac_loader_pkg::*;
  logic clock;
  logic rstn = 1'b0;
  logic frame_valid = 1'b0;
  logic frame_last = 1'b0;
  logic frame_ready, busy;
  frame_t frame_data = 12'h000;
  code_t channel_outputs [12];
  logic [15:0] code_step_level [12];
  code_t exp_code [12];
  int err_total = 0;
  int comparisons = 0;
  dac_link_if link ();
  dac_serial_host dac_serial_host_i (.clock(clock), .rstn(rstn),
    .link(link.host), .frame_valid(frame_valid), .frame_ready(frame_ready),
    .frame_data(frame_data), .frame_last(frame_last), .busy(busy));
  dac_channel_loader dac_channel_loader_i (.clock(clock), .rstn(rstn),
    .link(link.device), .channel_outputs(channel_outputs),
    .code_step_level(code_step_level));
  dac_link_properties dac_link_properties_i (.clock(clock), .rstn(rstn),
    .serial_frame_in(link.serial_frame_in), .shift_clock(link.shift_clock),
    .latch_strobe(link.latch_strobe),
    .serial_frame_out(link.serial_frame_out));
  // ----
  // clock, tasks
  // ----
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : finish_test
  // latch index, or -1 for the don't-care codes (bit 8 weighs eight)
  function automatic int target(input frame_t f);
    addr_t a;
    a = {f[8], f[9], f[10], f[11]};
    return (a >= 4'h1 && a <= 4'hC) ? int'(a) - 1 : -1;
  endfunction : target
  // request held from a falling edge until a rising edge takes it
  task automatic send(input frame_t f, input logic last);
    @(negedge clock);
    frame_valid = 1'b1;
    frame_data = f;
    frame_last = last;
    for (int n = 0; n < 2000 && frame_ready !== 1'b1; n++) @(negedge clock);
    if (frame_ready !== 1'b1) begin
      err_total++;
      $display("ERROR %0t ready timeout got %h exp %h", $time,
        frame_ready, 1'b1);
    end
    @(negedge clock);
    frame_valid = 1'b0;
    // taken at the edge just passed: busy now, first bit on the line
    comparisons++;
    if ({busy, link.serial_frame_in} !== {1'b1, f[11]}) begin
      err_total++;
      $display("ERROR %0t start got %h exp %h", $time,
        {busy, link.serial_frame_in}, {1'b1, f[11]});
    end
  endtask : send
  // only the frame left in the shift register at the strobe counts
  task automatic load(input frame_t f, input frame_t lead, input logic two);
    int n;
    logic [23:0] got;
    logic [23:0] exp_lvl;
    if (two) send(lead, 1'b0);
    send(f, 1'b1);
    for (n = 0; n < 2000 && busy !== 1'b0; n++) @(negedge clock);
    if (busy !== 1'b0) begin
      err_total++;
      $display("ERROR %0t busy timeout got %h exp %h", $time, busy, 1'b0);
    end
    repeat (8) @(negedge clock);
    n = target(f);
    if (n >= 0) exp_code[n] = f[7:0];
    // chain output must show the top bit of the frame left inside
    comparisons++;
    if (link.serial_frame_out !== f[11]) begin
      err_total++;
      $display("ERROR %0t chain out got %h exp %h", $time,
        link.serial_frame_out, f[11]);
    end
    // level word is code times 65535/255, that is code times 257
    for (int i = 0; i < 12; i++) begin
      got = {channel_outputs[i], code_step_level[i]};
      exp_lvl = {exp_code[i], 16'(exp_code[i] * 257)};
      comparisons++;
      if (got !== exp_lvl) begin
        err_total++;
        $display("ERROR %0t ch %0d got %h exp %h", $time, i + 1,
          got, exp_lvl);
      end
    end
  endtask : load
  // ----
  // main sequence: every address code, then random and paired frames
  // ----
  initial begin
    void'($urandom(32'haea7));
    for (int i = 0; i < 12; i++) exp_code[i] = 8'h00;
    repeat (5) @(negedge clock);
    rstn = 1'b1;
    for (int t = 0; t < 40; t++) begin
      frame_t f;
      f = frame_t'($urandom);
      if (t < 16) f[11:8] = {t[0], t[1], t[2], t[3]};
      if (t == 12) f[7:0] = 8'hFF;
      if (t == 1) f[7:0] = 8'h00;
      load(f, frame_t'($urandom), t >= 30);
      $display("test %0d frame %h done", t, f);
    end
    finish_test();
  end
  // watchdog well past the expected run of some 32000 cycles
  initial begin
    #600000;
    err_total++;
    finish_test();
  end
endmodule : tb_serial_dac_channel_loader
